// >>> qsp_top.sv
/*
  Address decode and interrupt routing for a four-channel serial card, with an APB
  window for control and observation.
  Assumes host I/O strobes and switch inputs are synchronous to pclk; switch
  inputs are high when the switch is ON.
*/
`timescale 1ns/1ns
`default_nettype none
module qsp_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [qsp_pkg::IO_AW-1:0] io_addr,
  input wire logic io_rd_n,
  input wire logic io_wr_n,
  input wire logic io_aen,
  input wire logic mode_select_switch,
  input wire logic address_bank_switch,
  input wire logic interrupt_share_switch,
  input wire logic reserved_switch,
  input wire logic [qsp_pkg::NLINE-1:0] irq_enable_switch,
  input wire logic [qsp_pkg::NCHAN-1:0] chan_irq,
  output logic [qsp_pkg::NCHAN-1:0] chan_sel,
  output logic vector_rd,
  output logic [7:0] io_data_o,
  output logic io_data_oe,
  output logic [qsp_pkg::NLINE-1:0] irq_line_o,
  output logic [qsp_pkg::NLINE-1:0] irq_line_oe
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  qsp_dec_if dif ();
  logic [1:0] ctrl_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic [qsp_pkg::NCHAN-1:0] sel_q;
  logic vec_q;
  logic [7:0] vdata_q;
  logic vdata_oe_q;
  logic [qsp_pkg::NLINE-1:0] line_q;
  logic [qsp_pkg::NLINE-1:0] line_oe_q;
  logic [qsp_pkg::NLINE-1:0] line_req;
  logic [qsp_pkg::NLINE-1:0] line_drive;
  logic [qsp_pkg::IO_AW-1:0] last_addr_q;
  logic [qsp_pkg::NCHAN:0] last_sel_q;
  logic [31:0] count_q;
  logic [31:0] count_d;
  logic io_cycle;
  logic group_irq;
  logic apb_acc;
  logic apb_wr;
  logic apb_rd;
  logic addr_ok;
  logic hit;
  logic [31:0] rd_word;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // A bus cycle is a read or write strobe with no DMA address in control
  assign io_cycle = (!io_rd_n || !io_wr_n) && !io_aen;
  assign dif.addr = io_addr;
  assign dif.compat = mode_select_switch;
  assign dif.bank_on = address_bank_switch;
  assign dif.active = io_cycle && ctrl_q[qsp_pkg::CTRL_DEC_EN];

  qsp_addr_decode u_dec (
    .d(dif.dec)
  );

  assign hit = (|dif.sel) || dif.vec;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_q <= '0;
      vec_q <= 1'b0;
    end else begin
      sel_q <= dif.sel; // R11
      vec_q <= dif.vec && !io_rd_n; // R10
    end
  end

  // ----------------------------------------------------------------
  // Interrupt vector byte
  // ----------------------------------------------------------------
  // Low nibble shows which channels are requesting; the host polls it
  // to find the source once the shared line fires.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vdata_q <= 8'h00;
      vdata_oe_q <= 1'b0;
    end else begin
      vdata_q <= {4'h0, chan_irq};
      vdata_oe_q <= dif.vec && !io_rd_n; // R10
    end
  end

  // ----------------------------------------------------------------
  // Interrupt routing
  // ----------------------------------------------------------------
  // In compatible mode the first two channels have fixed lines, so only
  // the upper pair reaches the switch-selected line.
  assign group_irq = mode_select_switch ? (chan_irq[2] || chan_irq[3]) : (|chan_irq); // R4

  genvar gi;
  generate
    for (gi = 0; gi < qsp_pkg::NLINE; gi = gi + 1) begin : g_line
      logic fixed_en;
      logic fixed_req;
      if (gi == qsp_pkg::LINE_IRQ4) begin : g_irq4
        assign fixed_en = mode_select_switch;
        assign fixed_req = mode_select_switch && chan_irq[0]; // R3
      end else if (gi == qsp_pkg::LINE_IRQ3) begin : g_irq3
        assign fixed_en = mode_select_switch;
        assign fixed_req = mode_select_switch && chan_irq[1]; // R3
      end else begin : g_none
        assign fixed_en = 1'b0;
        assign fixed_req = 1'b0;
      end
      assign line_req[gi] = ctrl_q[qsp_pkg::CTRL_IRQ_EN] &&
                            (fixed_req || (irq_enable_switch[gi] && group_irq)); // R4 R6
      assign line_drive[gi] = fixed_en || irq_enable_switch[gi];
    end
  endgenerate

  // Switch ON means sharing is off: the enabled line is driven both ways.
  // With sharing on, the board only drives while requesting so another
  // board can drive the same line.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_q <= '0;
      line_oe_q <= '0;
    end else if (interrupt_share_switch) begin
      line_q <= line_req;
      line_oe_q <= line_drive; // R7
    end else begin
      line_q <= line_req;
      line_oe_q <= line_req;
    end
  end

  // ----------------------------------------------------------------
  // Decode history
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_addr_q <= '0;
      last_sel_q <= '0;
    end else if (hit) begin
      last_addr_q <= io_addr;
      last_sel_q <= {dif.vec, dif.sel};
    end
  end

  // A decode in the same cycle as a software clear still counts
  always_comb begin
    count_d = count_q;
    if (apb_wr && paddr == qsp_pkg::REG_COUNT) begin
      count_d = qsp_pkg::CNT_RESET;
    end
    if (hit && !(vec_q || |sel_q)) begin
      count_d = count_d + qsp_pkg::CNT_ONE;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= qsp_pkg::CNT_RESET;
    end else begin
      count_q <= count_d;
    end
  end

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  // One wait state: pready is registered so every output stays a flop.
  assign apb_acc = psel && penable && !pready_q;
  // Writes land on the edge that completes the transfer, with pready seen high
  assign apb_wr = psel && penable && pready_q && pwrite;
  assign apb_rd = apb_acc && !pwrite;
  assign addr_ok = (paddr == qsp_pkg::REG_CTRL) || (paddr == qsp_pkg::REG_STATUS) ||
                   (paddr == qsp_pkg::REG_LAST) || (paddr == qsp_pkg::REG_COUNT);

  always_comb begin
    rd_word = qsp_pkg::ZERO_WORD;
    case (paddr)
      qsp_pkg::REG_CTRL: begin
        rd_word[1:0] = ctrl_q;
      end
      qsp_pkg::REG_STATUS: begin
        rd_word[qsp_pkg::ST_SW_LSB +: 4] = {reserved_switch, interrupt_share_switch,
                                             address_bank_switch, mode_select_switch};
        rd_word[qsp_pkg::ST_IRQSW_LSB +: qsp_pkg::NLINE] = irq_enable_switch;
        rd_word[qsp_pkg::ST_CHIRQ_LSB +: qsp_pkg::NCHAN] = chan_irq;
      end
      qsp_pkg::REG_LAST: begin
        rd_word[qsp_pkg::IO_AW-1:0] = last_addr_q;
        rd_word[qsp_pkg::LAST_SEL_LSB +: qsp_pkg::NCHAN+1] = last_sel_q;
      end
      qsp_pkg::REG_COUNT: begin
        rd_word = count_q;
      end
      default: begin
        rd_word = qsp_pkg::ZERO_WORD;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= qsp_pkg::CTRL_RESET;
    end else if (apb_wr && paddr == qsp_pkg::REG_CTRL && pstrb[0]) begin
      ctrl_q <= pwdata[1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= qsp_pkg::ZERO_WORD;
    end else begin
      pready_q <= apb_acc;
      pslverr_q <= apb_acc && !addr_ok;
      prdata_q <= apb_rd ? rd_word : qsp_pkg::ZERO_WORD;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign chan_sel = sel_q;
  assign vector_rd = vec_q;
  assign io_data_o = vdata_q;
  assign io_data_oe = vdata_oe_q;
  assign irq_line_o = line_q;
  assign irq_line_oe = line_oe_q;
endmodule // qsp_top
`default_nettype wire

// >>> qsp_pkg.sv
/*
  Constants for the four-channel serial card address decode and interrupt routing.
  Assumes an APB master on pclk and host I/O bus strobes already synchronous to pclk.
*/
`default_nettype none
// Operation
// R1: In compatible mode channel 1 answers as legacy_serial_port_one and channel 2 as legacy_serial_port_two.
// R2: In compatible mode channel 1 decodes at 03F8-03FFh and channel 2 at 02F8-02FFh regardless of bank.
// R3: In compatible mode channel 1 interrupts go to IRQ4 and channel 2 to IRQ3 without any switch.
// R4: In compatible mode channels 3 and 4 interrupt only on the one switch-selected request line.
// R5: In enhanced mode no channel answers at a legacy serial-port address.
// R6: The configurer enables exactly one switchable request line, IRQ2 by default.
// R7: With sharing off the board drives its request line actively as a sole source.
// R8: The bank switch places channels 3 and 4 (compatible) or all four (enhanced).
// R9: Enhanced blocks run consecutively from 02A0h with the bank switch on, 01A0h with it off.
// R10: The top address of channel 4's block returns the interrupt vector instead of the channel.
// R11: At most one channel select or vector read is produced per I/O cycle.
package qsp_pkg;
  // ----------------------------------------------------------------
  // Host I/O address map
  // ----------------------------------------------------------------
  localparam int unsigned IO_AW = 10;
  localparam int unsigned BLK_AW = 7;
  localparam int unsigned NCHAN = 4;
  localparam int unsigned NLINE = 6;
  localparam logic [BLK_AW-1:0] BLK_LEGACY_ONE = 7'h7f;
  localparam logic [BLK_AW-1:0] BLK_LEGACY_TWO = 7'h5f;
  localparam logic [BLK_AW-1:0] BLK_BASE_BANK_ON = 7'h54;
  localparam logic [BLK_AW-1:0] BLK_BASE_BANK_OFF = 7'h34;
  localparam logic [1:0] CH_COMPAT_FIRST = 2'h2;
  localparam logic [1:0] CH_LAST = 2'h3;
  localparam logic [2:0] VEC_OFFSET = 3'h7;
  // Interrupt lines are indexed from IRQ2
  localparam int unsigned LINE_IRQ3 = 1;
  localparam int unsigned LINE_IRQ4 = 2;
  // ----------------------------------------------------------------
  // APB register map
  // ----------------------------------------------------------------
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_STATUS = 12'h004;
  localparam logic [11:0] REG_LAST = 12'h008;
  localparam logic [11:0] REG_COUNT = 12'h00c;
  localparam int unsigned CTRL_DEC_EN = 0;
  localparam int unsigned CTRL_IRQ_EN = 1;
  localparam logic [1:0] CTRL_RESET = 2'h3;
  localparam int unsigned ST_SW_LSB = 0;
  localparam int unsigned ST_IRQSW_LSB = 4;
  localparam int unsigned ST_CHIRQ_LSB = 10;
  localparam int unsigned LAST_SEL_LSB = 10;
  localparam logic [31:0] CNT_RESET = 32'h0000_0000;
  localparam logic [31:0] CNT_ONE = 32'h0000_0001;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
endpackage
`default_nettype wire

// >>> qsp_dec_if.sv
/*
  Bundle between the top and the address decoder.
  Assumes both ends sit on pclk; the decoder is purely combinational.
*/
`timescale 1ns/1ns
`default_nettype none
interface qsp_dec_if;
  logic [qsp_pkg::IO_AW-1:0] addr;
  logic compat;
  logic bank_on;
  logic active;
  logic [qsp_pkg::NCHAN-1:0] sel;
  logic vec;
  modport top (output addr, output compat, output bank_on, output active,
               input sel, input vec);
  modport dec (input addr, input compat, input bank_on, input active,
               output sel, output vec);
endinterface
`default_nettype wire

// >>> qsp_addr_decode.sv
/*
  Combinational address decoder for the four channels and the vector byte.
  Assumes address and switches are stable during the I/O cycle.
*/
`timescale 1ns/1ns
`default_nettype none
module qsp_addr_decode (
  qsp_dec_if.dec d
);
  logic [qsp_pkg::BLK_AW-1:0] blk;
  logic [qsp_pkg::BLK_AW-1:0] base;
  logic [qsp_pkg::BLK_AW-1:0] rel;
  logic in_bank;
  logic top_byte;

  assign blk = d.addr[qsp_pkg::IO_AW-1:3];
  assign base = d.bank_on ? qsp_pkg::BLK_BASE_BANK_ON : qsp_pkg::BLK_BASE_BANK_OFF; // R8 R9
  assign rel = blk - base;
  assign in_bank = (rel < qsp_pkg::BLK_AW'(qsp_pkg::NCHAN));
  assign top_byte = (d.addr[2:0] == qsp_pkg::VEC_OFFSET);

  // ----------------------------------------------------------------
  // Channel selects, one-hot by construction
  // ----------------------------------------------------------------
  always_comb begin
    d.sel = '0;
    d.vec = 1'b0;
    if (d.active) begin
      if (d.compat && blk == qsp_pkg::BLK_LEGACY_ONE) begin
        d.sel[0] = 1'b1; // R1 R2
      end else if (d.compat && blk == qsp_pkg::BLK_LEGACY_TWO) begin
        d.sel[1] = 1'b1; // R1 R2
      end else if (in_bank && (!d.compat || rel[1:0] >= qsp_pkg::CH_COMPAT_FIRST)) begin // R5 R8
        if (rel[1:0] == qsp_pkg::CH_LAST && top_byte) begin
          d.vec = 1'b1; // R10
        end else begin
          d.sel[rel[1:0]] = 1'b1; // R9 R11
        end
      end
    end
  end
endmodule // qsp_addr_decode
`default_nettype wire

// >>> qsp_host_model.sv
/*
  Host processor side of the I/O expansion bus: address, strobes and AEN.
  Assumes callers enter its tasks just after a rising edge of clk.
*/
`timescale 1ns/1ns
`default_nettype none
module qsp_host (
  input wire logic clk,
  output logic [9:0] io_addr,
  output logic io_rd_n,
  output logic io_wr_n,
  output logic io_aen
);
  // ------------------------------
  // Bus cycles
  // ------------------------------
  initial begin
    io_addr = 10'h155;
    io_rd_n = 1'b1;
    io_wr_n = 1'b1;
    io_aen = 1'b0;
  end
  // Strobe sampled at the next edge; returns just after it
  task automatic cyc(input logic [9:0] a, input logic rd, input logic aen);
    io_addr <= a;
    io_aen <= aen;
    if (rd) begin
      io_rd_n <= 1'b0;
    end else begin
      io_wr_n <= 1'b0;
    end
    @(posedge clk);
    #1;
  endtask
  // Released address is inverted so a stale value is never mistaken for a hold
  task automatic idle();
    @(posedge clk);
    io_rd_n <= 1'b1;
    io_wr_n <= 1'b1;
    io_aen <= 1'b0;
    io_addr <= ~io_addr;
    @(posedge clk);
  endtask
endmodule // qsp_host
`default_nettype wire

// >>> qsp_top_chk.sv
/*
  Assertions on the decode and interrupt outputs of qsp_top.
  Assumes CTRL keeps decode and interrupts enabled throughout.
*/
`timescale 1ns/1ns
`default_nettype none
module qsp_top_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [qsp_pkg::IO_AW-1:0] io_addr,
  input wire logic io_rd_n,
  input wire logic io_wr_n,
  input wire logic io_aen,
  input wire logic mode_select_switch,
  input wire logic address_bank_switch,
  input wire logic interrupt_share_switch,
  input wire logic [qsp_pkg::NLINE-1:0] irq_enable_switch,
  input wire logic [qsp_pkg::NCHAN-1:0] chan_irq,
  input wire logic [qsp_pkg::NCHAN-1:0] chan_sel,
  input wire logic vector_rd,
  input wire logic [7:0] io_data_o,
  input wire logic io_data_oe,
  input wire logic [qsp_pkg::NLINE-1:0] irq_line_o,
  input wire logic [qsp_pkg::NLINE-1:0] irq_line_oe
);
  // ------------------------------
  // Properties
  // ------------------------------
  logic act, cmp, p34;
  logic [4:0] base;
  assign act = (!io_rd_n || !io_wr_n) && !io_aen;
  assign cmp = mode_select_switch;
  assign p34 = irq_enable_switch[0] && (chan_irq[2] || chan_irq[3]);
  assign base = address_bank_switch ? 5'h15 : 5'h0d;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_cmp_at(logic [6:0] blk);
    cmp && act && io_addr[9:3] == blk;
  endsequence
  sequence s_vec_hit;
    !io_rd_n && !io_aen && io_addr == {base, 5'h1f};
  endsequence
  a_legacy_one: assert property (s_cmp_at(7'h7f) |=> chan_sel == 4'h1)
    else $error("channel 1 legacy select wrong");
  a_legacy_two: assert property (s_cmp_at(7'h5f) |=> chan_sel == 4'h2)
    else $error("channel 2 legacy select wrong");
  a_enh_legacy: assert property (!cmp && act && (io_addr[9:3] == 7'h7f ||
    io_addr[9:3] == 7'h5f) |=> chan_sel == 4'h0) else $error("legacy hit in enhanced");
  a_enh_block: assert property (!cmp && act && io_addr[9:5] == base && io_addr[4:0] != 5'h1f
    |=> chan_sel == 4'h1 << $past(io_addr[4:3])) else $error("enhanced select wrong");
  a_cmp_upper: assert property (cmp && act && io_addr[9:4] == {base, 1'b1} &&
    io_addr[3:0] != 4'hf |=> chan_sel == ($past(io_addr[3]) ? 4'h8 : 4'h4))
    else $error("channel 3 or 4 select wrong");
  a_vec_read: assert property (s_vec_hit |=> vector_rd && io_data_oe &&
    io_data_o == {4'h0, $past(chan_irq)}) else $error("vector read wrong");
  a_sel_single: assert property ($onehot0({chan_sel, vector_rd}))
    else $error("more than one select");
  a_irq_fixed: assert property (cmp && irq_enable_switch[2:1] == 2'h0
    |=> {irq_line_o[1], irq_line_o[2]} == $past(chan_irq[1:0])) else $error("fixed lines wrong");
  a_irq_pair: assert property (cmp |=> irq_line_o[0] == $past(p34))
    else $error("channel 3 or 4 line wrong");
  a_sole_drive: assert property (interrupt_share_switch
    |=> irq_line_oe[0] == $past(irq_enable_switch[0])) else $error("line drive wrong");
  a_share_open: assert property (!interrupt_share_switch |=> irq_line_oe == irq_line_o)
    else $error("shared drive wrong");
endmodule // qsp_top_chk
`default_nettype wire

// >>> testbench.sv
/*
  Self-checking bench for qsp_top: decode table, interrupts, APB window.
  Assumes qsp_host drives the I/O bus and qsp_top_chk watches the ports.
*/
`timescale 1ns/1ns
`default_nettype none
module testbench;
  // ------------------------------
  // Stimulus and checks
  // ------------------------------
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] pstrb = 4'hf, chan_irq = 4'h0, chan_sel;
  logic pready, pslverr, er, io_rd_n, io_wr_n, io_aen, vector_rd, io_data_oe;
  logic mode_select_switch = 1'b1, address_bank_switch = 1'b1, interrupt_share_switch = 1'b1;
  logic [5:0] irq_enable_switch = 6'h01;
  logic [5:0] irq_line_o, irq_line_oe;
  logic [9:0] io_addr;
  logic [7:0] io_data_o;
  int err_total = 0, checks = 0;
  // Row: {mode, bank}, address, {vector, select}
  logic [23:0] rows [30] = '{24'h33f801, 24'h33ff01, 24'h32f802, 24'h32ff02, 24'h32b004,
    24'h32b704, 24'h32b808, 24'h32be08, 24'h32bf10, 24'h32a000, 24'h32a800, 24'h23f801,
    24'h22f802, 24'h21b004, 24'h21be08, 24'h21bf10, 24'h22b000, 24'h12a001, 24'h12af02,
    24'h12b004, 24'h12b808, 24'h12bf10, 24'h13f800, 24'h12f800, 24'h01a001, 24'h01a802,
    24'h01b704, 24'h01be08, 24'h01bf10, 24'h02a000};
  always #20 pclk = ~pclk;
  qsp_host host_u (.clk(pclk), .io_addr, .io_rd_n, .io_wr_n, .io_aen);
  qsp_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
    .pready, .pslverr, .io_addr, .io_rd_n, .io_wr_n, .io_aen, .mode_select_switch,
    .address_bank_switch, .interrupt_share_switch, .reserved_switch(1'b0), .irq_enable_switch,
    .chan_irq, .chan_sel, .vector_rd, .io_data_o, .io_data_oe, .irq_line_o, .irq_line_oe);
  task automatic results();
    if (err_total == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h, want %h", $time, got, exp);
    end
  endtask
  task automatic io(input logic [9:0] a, input logic r, input logic aen, input logic [5:0] e);
    host_u.cyc(a, r, aen);
    cmp(32'({io_data_oe, vector_rd, chan_sel}), 32'(e));
    host_u.idle();
  endtask
  // Bounded wait on pready; data and error taken at the same edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      err_total++;
      results();
    end
    // Idle edge so a following setup never re-assigns psel in this step
    @(posedge pclk);
  endtask
  initial begin
    repeat (5) @(posedge pclk);
    cmp(32'({pready, vector_rd, chan_sel, irq_line_oe}), 32'h0);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (rows[i]) begin
      mode_select_switch <= rows[i][21];
      address_bank_switch <= rows[i][20];
      io(rows[i][17:8], 1'b1, 1'b0, {rows[i][4], rows[i][4:0]});
    end
    mode_select_switch <= 1'b1;
    address_bank_switch <= 1'b1;
    chan_irq <= 4'h9;
    host_u.cyc(10'h2bf, 1'b1, 1'b0);
    cmp(32'(io_data_o), 32'h09);
    host_u.idle();
    io(10'h2bf, 1'b0, 1'b0, 6'h00);
    io(10'h3f8, 1'b1, 1'b1, 6'h00);
    io(10'h3f8, 1'b0, 1'b0, 6'h01);
    chan_irq <= 4'h5;
    repeat (2) @(posedge pclk);
    #1;
    cmp(32'(irq_line_o), 32'h05);
    cmp(32'(irq_line_oe), 32'h07);
    @(posedge pclk);
    mode_select_switch <= 1'b0;
    irq_enable_switch <= 6'h20;
    chan_irq <= 4'h8;
    repeat (2) @(posedge pclk);
    #1;
    cmp(32'({irq_line_o, irq_line_oe}), 32'h820);
    @(posedge pclk);
    interrupt_share_switch <= 1'b0;
    chan_irq <= 4'h0;
    repeat (2) @(posedge pclk);
    #1;
    cmp(32'({irq_line_o, irq_line_oe}), 32'h0);
    @(posedge pclk);
    pstrb <= 4'h0;
    apb(1'b1, 12'h000, 32'h0);
    pstrb <= 4'hf;
    apb(1'b0, 12'h000, 32'h0);
    cmp(rd, 32'h3);
    apb(1'b0, 12'h010, 32'h0);
    cmp(32'({er, rd[30:0]}), 32'h8000_0000);
    mode_select_switch <= 1'b1;
    apb(1'b1, 12'h00c, 32'h0);
    io(10'h3f8, 1'b1, 1'b0, 6'h01);
    apb(1'b0, 12'h00c, 32'h0);
    cmp(rd, 32'h1);
    apb(1'b0, 12'h008, 32'h0);
    cmp(rd, 32'h0000_07f8);
    apb(1'b0, 12'h004, 32'h0);
    cmp(32'(rd[13:0]), 32'({chan_irq, irq_enable_switch, 1'b0, interrupt_share_switch,
      address_bank_switch, mode_select_switch}));
    // Mid-run reset: outputs clear at once, the decode count starts over
    presetn <= 1'b0;
    @(posedge pclk);
    #1;
    cmp(32'({pready, pslverr, vector_rd, io_data_oe, chan_sel, irq_line_o, irq_line_oe}), 32'h0);
    @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 12'h00c, 32'h0);
    cmp(rd, 32'h0);
    results();
  end
endmodule // testbench
bind qsp_top qsp_top_chk chk_u (.pclk, .presetn, .io_addr, .io_rd_n, .io_wr_n, .io_aen,
  .mode_select_switch, .address_bank_switch, .interrupt_share_switch, .irq_enable_switch,
  .chan_irq, .chan_sel, .vector_rd, .io_data_o, .io_data_oe, .irq_line_o, .irq_line_oe);
`default_nettype wire
